// *** hw/suqt_bridge.sv ***
`timescale 1ns/1ps
// What this block does
// R1: Host enables watchdog via second config register, then polls watchdog alert register; the bridge has no watchdog and answers both with idle bytes.
// R2: Load command, length byte, message bytes fill load queue without transmitting.
// R3: Single-byte advance command starts sending the loaded message onto the UART.
// R4: Receive status bit 1 flags a complete message; host polls it.
// R5: Read-next-message command shifts out received bytes in arrival order.
// R6: Readout ends with safety status byte, then CRC over all preceding readout bytes.
// R7: Broadcast write message: command, address, low, high, check byte, seed; length 6.
// R8: Broadcast read message: command, address, data-check seed, check byte, seed.
// R9: Each chained slave increments the alive counter as the message passes.
// R10: Broadcast read reply holds low then high byte per slave, highest first.
// R11: Returned data-check byte is zero when all slave status bits are clear.
// R12: Host reads status after readout, clears error and overflow flags if set.
// R13: Alive counter follows the check byte, so it is never covered by it.
// R14: Packet check is CRC-8 and the safety status byte comes just before the check byte in every readout.
module suqt_bridge
  import suqt_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic SPI_SCLK_I,
  input wire logic SPI_CS_N_I,
  input wire logic SPI_MOSI_I,
  output logic SPI_MISO_O,
  output logic SPI_MISO_OE_O,
  output logic TX_VALID_O,
  output logic [7:0] TX_DATA_O,
  input wire logic TX_READY_I,
  output logic TX_BUSY_O,
  input wire logic RX_VALID_I,
  input wire suqt_rx_t RX_I,
  input wire logic [7:0] SAFETY_STATUS_I
);

  // ==========================================================================
  // Pin synchronisers: bit 0 is the first stage and is read only by bit 1.
  logic [2:0] sclk_sync_reg, cs_sync_reg, mosi_sync_reg;
  logic sclk_stable_reg, cs_stable_reg;

  // A clock or select pin change counts once the second and third stages agree.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      sclk_sync_reg <= 3'h0;
      cs_sync_reg <= 3'h7;
      mosi_sync_reg <= 3'h0;
      sclk_stable_reg <= 1'b0;
      cs_stable_reg <= 1'b1;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], SPI_SCLK_I};
      cs_sync_reg <= {cs_sync_reg[1:0], SPI_CS_N_I};
      mosi_sync_reg <= {mosi_sync_reg[1:0], SPI_MOSI_I};
      if (sclk_sync_reg[1] == sclk_sync_reg[2]) sclk_stable_reg <= sclk_sync_reg[2];
      if (cs_sync_reg[1] == cs_sync_reg[2]) cs_stable_reg <= cs_sync_reg[2];
    end
  end

  // Edge strobes for the SPI link, mode 0 with the clock idling low.
  wire sclk_agree = sclk_sync_reg[1] == sclk_sync_reg[2];
  wire cs_agree = cs_sync_reg[1] == cs_sync_reg[2];
  wire cs_active = !cs_stable_reg;
  wire sclk_rise = cs_active && sclk_agree && sclk_sync_reg[2] && !sclk_stable_reg;
  wire sclk_fall = cs_active && sclk_agree && !sclk_sync_reg[2] && sclk_stable_reg;
  wire cs_fall = cs_agree && !cs_sync_reg[2] && cs_stable_reg;
  wire cs_rise = cs_agree && cs_sync_reg[2] && !cs_stable_reg;

  // ==========================================================================
  // SPI byte engine.
  suqt_phase_t phase_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] rx_shift_reg, tx_shift_reg, out_hold_reg, crc_reg;
  logic load_pending_reg;
  logic [5:0] idx_reg;

  wire byte_done = sclk_rise && bit_cnt_reg == LAST_BIT;
  wire [7:0] in_byte = {rx_shift_reg[6:0], mosi_sync_reg[2]};

  // ==========================================================================
  // Load queue, receive buffer and status state.
  logic [7:0] lq_mem [QUEUE_DEPTH];
  logic [7:0] rx_mem [QUEUE_DEPTH];
  logic [5:0] lq_len_reg, rx_count_reg, tx_idx_reg;
  logic tx_busy_reg, rx_stop_reg, rx_err_reg, rx_ovf_reg;
  logic [7:0] rx_status;

  // Status byte as the host sees it.
  always_comb begin
    rx_status = 8'h00;
    rx_status[RX_EMPTY_BIT] = rx_count_reg == 6'h00;
    rx_status[RX_STOP_BIT] = rx_stop_reg; // R4
    rx_status[RX_ERR_BIT] = rx_err_reg;
    rx_status[RX_OVERFLOW_BIT] = rx_ovf_reg;
  end

  // Command decode at the end of the first byte of a transaction.
  wire at_cmd = phase_reg == PH_CMD && byte_done;
  wire cmd_load = at_cmd && in_byte == CMD_LOAD_QUEUE && !tx_busy_reg;
  wire cmd_adv = at_cmd && in_byte == CMD_ADVANCE_QUEUE;
  wire cmd_stat = at_cmd && in_byte == CMD_READ_RX_STATUS;
  wire cmd_wstat = at_cmd && in_byte == CMD_WRITE_RX_STATUS;
  wire cmd_read = at_cmd && in_byte == CMD_READ_NEXT_MESSAGE;

  // Readout position: received bytes, then safety byte, then the check byte.
  wire [5:0] rd_pos = (phase_reg == PH_CMD) ? 6'h00 : idx_reg;
  wire rd_active = cmd_read || (phase_reg == PH_READ && byte_done);
  wire rd_is_data = rd_pos < rx_count_reg;
  wire rd_is_safety = rd_pos == rx_count_reg;
  wire rd_is_crc = rd_pos == rx_count_reg + 6'h01;
  wire [7:0] rd_byte = rd_is_data ? rx_mem[rd_pos[QUEUE_AW-1:0]] : // R5
                       rd_is_safety ? SAFETY_STATUS_I : // R14
                       rd_is_crc ? crc_reg : SPI_IDLE_BYTE; // R6
  wire [7:0] crc_base = (phase_reg == PH_CMD) ? 8'h00 : crc_reg;
  wire [7:0] out_next = cmd_stat ? rx_status : (rd_active ? rd_byte : SPI_IDLE_BYTE);

  // Write to the status register clears error flags written as one.
  wire stat_wr = phase_reg == PH_WSTAT && byte_done;
  wire clr_err = stat_wr && in_byte[RX_ERR_BIT];
  wire clr_ovf = stat_wr && in_byte[RX_OVERFLOW_BIT];
  wire lq_store = phase_reg == PH_LOAD && byte_done && idx_reg < QUEUE_FULL;
  wire msg_done = cs_rise && phase_reg == PH_READ;

  // Shift registers; the response byte is loaded at the falling edge after a byte.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      bit_cnt_reg <= 3'h0;
      rx_shift_reg <= 8'h00;
      tx_shift_reg <= SPI_IDLE_BYTE;
      out_hold_reg <= SPI_IDLE_BYTE;
      load_pending_reg <= 1'b0;
    end else if (cs_fall) begin
      bit_cnt_reg <= 3'h0;
      tx_shift_reg <= SPI_IDLE_BYTE;
      load_pending_reg <= 1'b0;
    end else begin
      if (sclk_rise) begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        rx_shift_reg <= in_byte;
      end
      if (byte_done) begin
        out_hold_reg <= out_next;
        load_pending_reg <= 1'b1;
      end else if (sclk_fall) begin
        tx_shift_reg <= load_pending_reg ? out_hold_reg : {tx_shift_reg[6:0], 1'b0};
        load_pending_reg <= 1'b0;
      end
    end
  end

  // Transaction phase; it returns to the command phase only when chip select falls.
  always_ff @(posedge CLK_I) begin
    if (RST_I || cs_fall) begin
      phase_reg <= PH_CMD;
      idx_reg <= 6'h00;
      crc_reg <= 8'h00;
    end else if (byte_done) begin
      unique case (phase_reg)
        PH_CMD: begin
          phase_reg <= cmd_load ? PH_LEN : cmd_stat ? PH_STAT : cmd_wstat ? PH_WSTAT :
                       cmd_read ? PH_READ : PH_IGNORE;
          idx_reg <= cmd_read ? 6'h01 : 6'h00;
        end
        PH_LEN: phase_reg <= PH_LOAD;
        PH_LOAD: if (lq_store) idx_reg <= idx_reg + 6'h01;
        PH_READ: if (!rd_is_crc && rd_pos < QUEUE_FULL + 6'h01) idx_reg <= idx_reg + 6'h01;
        PH_STAT, PH_WSTAT, PH_IGNORE: phase_reg <= PH_IGNORE;
      endcase
      if (rd_active && (rd_is_data || rd_is_safety)) crc_reg <= suqt_crc8(crc_base, rd_byte); // R6
    end
  end

  // Load queue: bytes are kept verbatim, so the host's own check byte and
  // trailing alive counter go out untouched.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      lq_len_reg <= 6'h00;
    end else if (phase_reg == PH_LEN && byte_done) begin
      lq_len_reg <= 6'h00; // R2
    end else if (lq_store) begin
      lq_mem[idx_reg[QUEUE_AW-1:0]] <= in_byte; // R2 R13
      lq_len_reg <= idx_reg + 6'h01;
    end
  end

  // ==========================================================================
  // Transmit path through a two-entry buffer so a UART stall loses no byte.
  logic [7:0] buf_mem [2];
  logic buf_wr_reg, buf_rd_reg;
  logic [1:0] buf_cnt_reg;
  wire buf_in_ready = buf_cnt_reg != BUF_ENTRIES;
  wire buf_push = tx_busy_reg && buf_in_ready;
  wire buf_pop = TX_VALID_O && TX_READY_I;

  assign TX_VALID_O = buf_cnt_reg != 2'h0;
  assign TX_DATA_O = buf_mem[buf_rd_reg];
  assign TX_BUSY_O = tx_busy_reg;

  // Advance is ignored while a send runs or when the queue is empty.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      tx_busy_reg <= 1'b0;
      tx_idx_reg <= 6'h00;
    end else if (cmd_adv && !tx_busy_reg && lq_len_reg != 6'h00) begin
      tx_busy_reg <= 1'b1; // R3
      tx_idx_reg <= 6'h00;
    end else if (buf_push) begin
      tx_idx_reg <= tx_idx_reg + 6'h01;
      if (tx_idx_reg + 6'h01 == lq_len_reg) tx_busy_reg <= 1'b0;
    end
  end

  // Buffer pointers; the filling side stalls the queue reader when full.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      buf_wr_reg <= 1'b0;
      buf_rd_reg <= 1'b0;
      buf_cnt_reg <= 2'h0;
    end else begin
      if (buf_push) begin
        buf_mem[buf_wr_reg] <= lq_mem[tx_idx_reg[QUEUE_AW-1:0]]; // R3
        buf_wr_reg <= !buf_wr_reg;
      end
      if (buf_pop) buf_rd_reg <= !buf_rd_reg;
      buf_cnt_reg <= buf_cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  // ==========================================================================
  // Receive buffer: one message; later bytes overflow until it is read out.
  wire rx_byte = RX_VALID_I && !RX_I.stop;
  wire rx_room = !rx_stop_reg && rx_count_reg != QUEUE_FULL;
  wire ovf_set = rx_byte && !rx_room;
  wire err_set = RX_VALID_I && RX_I.err;

  // An error or overflow event in the same cycle as its clear wins over the clear; for the stop flag the clear wins.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      rx_count_reg <= 6'h00;
      rx_stop_reg <= RX_STATUS_RESET[RX_STOP_BIT];
      rx_err_reg <= RX_STATUS_RESET[RX_ERR_BIT];
      rx_ovf_reg <= RX_STATUS_RESET[RX_OVERFLOW_BIT];
    end else begin
      if (msg_done) begin
        rx_count_reg <= 6'h00;
        rx_stop_reg <= 1'b0;
      end else if (rx_byte && rx_room) begin
        rx_mem[rx_count_reg[QUEUE_AW-1:0]] <= RX_I.data; // R5
        rx_count_reg <= rx_count_reg + 6'h01;
      end else if (RX_VALID_I && RX_I.stop && rx_count_reg != 6'h00) begin
        rx_stop_reg <= 1'b1; // R4
      end
      rx_err_reg <= err_set || (rx_err_reg && !clr_err); // R12
      rx_ovf_reg <= ovf_set || (rx_ovf_reg && !clr_ovf); // R12
    end
  end

  // MISO is driven only while the host selects the device.
  assign SPI_MISO_O = tx_shift_reg[7];
  assign SPI_MISO_OE_O = cs_active;

endmodule : suqt_bridge

// *** hw/suqt_pkg.sv ***
package suqt_pkg;

  // ==========================================================================
  // SPI command bytes.
  localparam logic [7:0] CMD_LOAD_QUEUE = 8'hc0;
  localparam logic [7:0] CMD_ADVANCE_QUEUE = 8'hb0;
  localparam logic [7:0] CMD_READ_NEXT_MESSAGE = 8'h93;
  localparam logic [7:0] CMD_READ_RX_STATUS = 8'h01;
  localparam logic [7:0] CMD_WRITE_RX_STATUS = 8'h00;
  localparam logic [7:0] SPI_IDLE_BYTE = 8'h00;

  // ==========================================================================
  // Receive status register bit positions and reset value.
  localparam int RX_EMPTY_BIT = 0;
  localparam int RX_STOP_BIT = 1;
  localparam int RX_ERR_BIT = 3;
  localparam int RX_OVERFLOW_BIT = 7;
  localparam logic [7:0] RX_STATUS_RESET = 8'h01;

  // ==========================================================================
  // Queue geometry: both the load queue and the receive buffer hold one message.
  localparam int QUEUE_DEPTH = 32;
  localparam int QUEUE_AW = 5;
  localparam logic [5:0] QUEUE_FULL = 6'h20;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] BUF_ENTRIES = 2'h2;

  // The check polynomial is a plain default, not taken from any real part.
  localparam logic [7:0] CRC8_POLY = 8'h07;

  // ==========================================================================
  // Types.
  typedef enum logic [2:0] {
    PH_CMD, PH_LEN, PH_LOAD, PH_STAT, PH_WSTAT, PH_READ, PH_IGNORE
  } suqt_phase_t;

  // One character from the UART receiver, or an end-of-message marker.
  typedef struct packed {
    logic stop;
    logic err;
    logic [7:0] data;
  } suqt_rx_t;

  // MSB-first CRC-8 step over one byte.
  function automatic logic [7:0] suqt_crc8(input logic [7:0] crc, input logic [7:0] b);
    logic [7:0] c;
    c = crc ^ b;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC8_POLY) : (c << 1);
    end
    return c;
  endfunction : suqt_crc8

endpackage : suqt_pkg

// *** verif/suqt_bridge_monitor.sv ***
`timescale 1ns/1ps
// ==========
// Port checker for the bridge.
module suqt_bridge_monitor (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic SPI_CS_N_I,
  input wire logic SPI_MISO_O,
  input wire logic SPI_MISO_OE_O,
  input wire logic TX_VALID_O,
  input wire logic [7:0] TX_DATA_O,
  input wire logic TX_READY_I,
  input wire logic TX_BUSY_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);
  // The select pin passes a synchroniser, so the enable may trail it by up to four edges.
  property p_oe_on;
    $fell(SPI_CS_N_I) |-> ##[2:4] SPI_MISO_OE_O;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("miso enable late");
  property p_oe_off;
    $rose(SPI_CS_N_I) |-> ##[2:4] !SPI_MISO_OE_O;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("miso release late");
  property p_oe_idle;
    SPI_CS_N_I [*5] |-> !SPI_MISO_OE_O;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("miso driven while idle");
  property p_miso_first;
    $rose(SPI_MISO_OE_O) |-> !SPI_MISO_O;
  endproperty
  a_miso_first: assert property (p_miso_first) else $error("first byte not zero");
  property p_tx_hold;
    TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte lost under stall");
  property p_valid_after_busy;
    $rose(TX_VALID_O) |-> $past(TX_BUSY_O);
  endproperty
  a_valid_after_busy: assert property (p_valid_after_busy) else $error("tx without send");
  property p_busy_in_frame;
    $rose(TX_BUSY_O) |-> SPI_MISO_OE_O;
  endproperty
  a_busy_in_frame: assert property (p_busy_in_frame) else $error("send outside frame");
  property p_reset_exit;
    $fell(RST_I) |-> !TX_VALID_O && !TX_BUSY_O && !SPI_MISO_OE_O;
  endproperty
  a_reset_exit: assert property (p_reset_exit) else $error("outputs active after reset");
  // Main scenarios that the bench is expected to reach.
  c_stall: cover property (TX_VALID_O && !TX_READY_I);
  c_busy: cover property ($rose(TX_BUSY_O));
  c_frame: cover property ($fell(SPI_MISO_OE_O));
endmodule : suqt_bridge_monitor

bind suqt_bridge suqt_bridge_monitor u_mon (
  .CLK_I(CLK_I), .RST_I(RST_I), .SPI_CS_N_I(SPI_CS_N_I), .SPI_MISO_O(SPI_MISO_O),
  .SPI_MISO_OE_O(SPI_MISO_OE_O), .TX_VALID_O(TX_VALID_O), .TX_DATA_O(TX_DATA_O),
  .TX_READY_I(TX_READY_I), .TX_BUSY_O(TX_BUSY_O)
);

// *** verif/suqt_host_model.sv ***
`timescale 1ns/1ps
// ==========
// Host model: mode 0 SPI master, 800 ns per bit, unrelated in phase to the system clock.
module suqt_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  int slow = 0;
  // Idle levels before the first frame.
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // One command per frame, MSB first; MISO is taken late in the high phase.
  task automatic frame(input logic [7:0] d[$], output logic [7:0] r[$]);
    logic [7:0] b;
    r = {};
    // Step off the system clock's edge first, so select never races the synchroniser.
    #13 cs_n_o = 1'b0;
    #537;
    foreach (d[i]) begin
      for (int k = 7; k >= 0; k--) begin
        mosi_o = d[i][k];
        #400 sclk_o = 1'b1;
        #300 b[k] = miso_i;
        #100 sclk_o = 1'b0;
      end
      r.push_back(b);
      #(slow);
    end
    #500 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #1300;
  endtask : frame
endmodule : suqt_host_model

// *** verif/tb_suqt_bridge.sv ***
`timescale 1ns/1ps
// ==========
// Bench for the SPI to UART queue bridge.
module tb_suqt_bridge import suqt_pkg::*; ();
  logic clk, rst, ready, rxv;
  suqt_rx_t rx;
  logic [7:0] safety;
  wire sclk, csn, mosi, miso, oe, txv, busy;
  wire [7:0] txd;
  int failures = 0;
  int check_count = 0;
  int seed = 32'h1e8e;
  logic [7:0] sent[$];

  suqt_bridge dut (.CLK_I(clk), .RST_I(rst), .SPI_SCLK_I(sclk), .SPI_CS_N_I(csn),
    .SPI_MOSI_I(mosi), .SPI_MISO_O(miso), .SPI_MISO_OE_O(oe), .TX_VALID_O(txv),
    .TX_DATA_O(txd), .TX_READY_I(ready), .TX_BUSY_O(busy), .RX_VALID_I(rxv), .RX_I(rx),
    .SAFETY_STATUS_I(safety));
  // A released MISO line shows the inverse, so a late output enable corrupts the read.
  wire miso_line = oe ? miso : ~miso;
  suqt_host_model h (.sclk_o(sclk), .cs_n_o(csn), .mosi_o(mosi), .miso_i(miso_line));

  // Clock at 10 MHz.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Far side of the transmit stream stalls at random and logs every accepted byte.
  always @(posedge clk) begin
    if (txv === 1'b1 && ready === 1'b1) sent.push_back(txd);
    ready <= ($random(seed) & 1) != 0;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Own check byte model, MSB first, polynomial 07h, so no design code is reused.
  function automatic logic [7:0] crc(input logic [7:0] q[$]);
    logic [7:0] c = 8'h00;
    foreach (q[i]) begin
      c ^= q[i];
      repeat (8) c = c[7] ? (c << 1) ^ 8'h07 : c << 1;
    end
    return c;
  endfunction : crc
  // Chained slaves hand back a message, then an end marker.
  task automatic feed(input logic [7:0] q[$], input logic e);
    foreach (q[i]) begin
      @(posedge clk) rxv <= 1'b1;
      rx <= '{stop: 1'b0, err: e, data: q[i]};
    end
    @(posedge clk) rx <= '{stop: 1'b1, err: 1'b0, data: 8'h00};
    @(posedge clk) rxv <= 1'b0;
  endtask : feed
  task automatic stat(input logic [7:0] exp);
    logic [7:0] r[$];
    h.frame({8'h01, 8'h00}, r);
    chk("status", exp, r[1]);
  endtask : stat
  // Load, send, answer, poll and read back one message.
  task automatic run(input logic [7:0] m[$], input logic [7:0] rep[$], input int len);
    logic [7:0] d[$], r[$], e[$];
    logic [7:0] v;
    int n = 0;
    d = m;
    d.push_front(8'(len));
    d.push_front(8'hc0);
    sent = {};
    h.frame(d, r);
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk("tx idle", 8'h00, {7'h00, txv});
    h.frame({8'hb0}, r);
    while (sent.size() < m.size() && n++ < 3000) @(posedge clk);
    chk("tx count", 8'(m.size()), 8'(sent.size()));
    foreach (m[i]) chk("tx byte", m[i], sent[i]);
    feed(rep, 1'b0);
    stat(8'h02);
    v = 8'($random(seed));
    safety <= v;
    e = rep;
    e.push_back(v);
    e.push_back(crc(e));
    d = {8'h93};
    foreach (e[i]) d.push_back(8'h00);
    h.frame(d, r);
    foreach (e[i]) chk("readout", e[i], r[i + 1]);
    stat(8'h01);
  endtask : run
  task automatic wrap_up;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // Watchdog cuts a hang short well past the expected run time.
  initial begin
    #4000000;
    failures++;
    wrap_up();
  end
  // Main sequence.
  initial begin
    logic [7:0] m[$], r[$];
    rst = 1'b1;
    rxv = 1'b0;
    rx = '0;
    ready = 1'b0;
    safety = 8'h00;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    stat(8'h01);
    h.frame({8'h88, 8'h87}, r);
    h.frame({8'h1c, 8'h00}, r);
    chk("alert read", 8'h00, r[1]);
    run({8'h02, 8'h64, 8'hff, 8'h7f, 8'h24, 8'h00},
      {8'h02, 8'h64, 8'hff, 8'h7f, 8'h02}, 6);
    run({8'h03, 8'h64, 8'h00, 8'ha6, 8'h00},
      {8'h03, 8'h64, 8'hff, 8'h7f, 8'hff, 8'h7f, 8'h00, 8'h02}, 9);
    m = {};
    repeat (1 + ($random(seed) & 15)) m.push_back(8'($random(seed)));
    h.slow = 2500;
    run(m, m, m.size());
    h.slow = 0;
    feed({8'h5a}, 1'b1);
    feed({8'h11}, 1'b0);
    stat(8'h8a);
    h.frame({8'h00, 8'h88}, r);
    stat(8'h02);
    h.frame({8'h93, 8'h00}, r);
    stat(8'h01);
    // An empty load leaves nothing to send, so the advance that follows is ignored.
    sent = {};
    h.frame({8'hc0, 8'h00}, r);
    h.frame({8'hb0}, r);
    @(negedge clk);
    chk("busy refused", 8'h00, {7'h00, busy});
    chk("tx refused", 8'h00, 8'(sent.size()));
    wrap_up();
  end
endmodule : tb_suqt_bridge
